// file: pkg/scfr_pkg.sv
// Package: register map, fields, resets and timing of the front configuration registers
package scfr_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [14:0] SCFR_ADDR_CFG_PRI = 15'h0000;
  localparam logic [14:0] SCFR_ADDR_DEV_CFG = 15'h0002;
  localparam logic [14:0] SCFR_ADDR_MAKER_LO = 15'h000C;
  localparam logic [14:0] SCFR_ADDR_MAKER_HI = 15'h000D;
  localparam logic [14:0] SCFR_ADDR_USR_CFG = 15'h0010;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SCFR_BIT_SOFT_RST = 7;
  localparam int SCFR_BIT_ASCEND = 5;
  localparam int SCFR_BIT_SDO_FLAG = 4;
  localparam int SCFR_BIT_ADDR_HOLD = 0;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SCFR_RST_CFG_PRI = 8'h30;
  localparam logic [7:0] SCFR_RST_DEV_CFG = 8'h00;
  localparam logic [7:0] SCFR_RST_USR_CFG = 8'h00;
  // Writable bit masks (flag bit 4 is read-only, reset bit self-clears)
  localparam logic [7:0] SCFR_WMASK_CFG_PRI = 8'h6F;
  // ----------------------------------------------------------------
  // Operating modes and timing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCFR_MODE_NORMAL = 2'b00,
    SCFR_MODE_RSVD1 = 2'b01,
    SCFR_MODE_RSVD2 = 2'b10,
    SCFR_MODE_PWRDN = 2'b11
  } scfr_mode_t;
  localparam int SCFR_CLK_MHZ = 40;
  localparam int SCFR_SOFT_RST_NS = 750;
  // Longest reset time: rounded down, at least one cycle
  localparam int SCFR_SOFT_RST_CYC = (SCFR_SOFT_RST_NS * SCFR_CLK_MHZ / 1000) < 1 ? 1 :
                                     (SCFR_SOFT_RST_NS * SCFR_CLK_MHZ / 1000);
endpackage

// file: core/scfr_addr_step.sv
// Streaming address stepper: next register address after each byte
`timescale 1ns/1ps
`default_nettype none
module scfr_addr_step
  import scfr_pkg::*;
#(
  parameter int AW = 15
) (
  // Current address and mode
  input wire logic [AW-1:0] addr_cur,
  input wire logic ascend,
  input wire logic hold,
  // Next address
  output logic [AW-1:0] addr_next
);
  initial begin
    if (AW < 5) $error("AW too small for register map");
  end

  // Hold wins over direction; otherwise step by one
  always_comb begin
    if (hold) begin
      addr_next = addr_cur;
    end else if (ascend) begin
      addr_next = addr_cur + AW'(1);
    end else begin
      addr_next = addr_cur - AW'(1);
    end
  end
endmodule // scfr_addr_step
`default_nettype wire

// file: core/scfr_regs.sv
// Front configuration register bank with streaming address control
// Behaviour
// - Reset bit 7 resets whole chip, registers too
// - Reset bit clears itself one cycle after the reset starts
// - Bit 5 picks ascending or descending address
// - Bit 4 flag always reads one
// - Mode field: 0 normal, 3 power down
// - Maker code at 0xC, read-only, fixed
// - Address hold keeps streaming address constant
// - Reset values 0x30, 0x00, 0x00
`timescale 1ns/1ps
`default_nettype none
module scfr_regs
  import scfr_pkg::*;
#(
  parameter int AW = 15,
  // Arbitrary neutral identification value
  parameter logic [15:0] MAKER_CODE = 16'h00A5
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Byte access from the serial front end
  input wire logic xfer_start,
  input wire logic [AW-1:0] xfer_addr,
  input wire logic byte_wr,
  input wire logic byte_rd,
  input wire logic [7:0] wr_data,
  // Read data and current address
  output logic [7:0] rd_data,
  output logic [AW-1:0] cur_addr,
  // Chip-wide controls
  output logic chip_rst,
  output logic busy,
  output logic power_down
);
  initial begin
    if (AW < 5) $error("AW too small for register map");
    if (SCFR_SOFT_RST_CYC > 1023) $error("soft reset count exceeds counter width");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] cfg_pri_r, cfg_pri_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [5:0] dev_rsvd_r, dev_rsvd_nxt;
  logic [7:0] usr_r, usr_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic [9:0] rst_cnt_r, rst_cnt_nxt;
  logic rst_act_r, rst_act_nxt;
  logic [AW-1:0] step_addr;
  logic [AW-1:0] acc_addr;
  logic soft_rst_req;

  // Decode shared by read and write paths
  function automatic logic is_addr(input logic [AW-1:0] a, input logic [14:0] ref_a);
    is_addr = (a == AW'(ref_a));
  endfunction

  // Address of this byte: fresh start or running pointer
  assign acc_addr = xfer_start ? xfer_addr : addr_r;
  assign soft_rst_req = byte_wr && is_addr(acc_addr, SCFR_ADDR_CFG_PRI) && wr_data[SCFR_BIT_SOFT_RST];

  scfr_addr_step #(.AW(AW)) u_step (
    .addr_cur(acc_addr),
    .ascend(cfg_pri_r[SCFR_BIT_ASCEND]),
    .hold(usr_r[SCFR_BIT_ADDR_HOLD]),
    .addr_next(step_addr)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Soft reset overrides all access; bus ignored while it runs
  always_comb begin
    cfg_pri_nxt = cfg_pri_r;
    mode_nxt = mode_r;
    dev_rsvd_nxt = dev_rsvd_r;
    usr_nxt = usr_r;
    addr_nxt = addr_r;
    rd_nxt = rd_r;
    rst_cnt_nxt = rst_cnt_r;
    rst_act_nxt = rst_act_r;
    if (rst_act_r) begin
      // Whole chip held; registers forced to reset values
      cfg_pri_nxt = SCFR_RST_CFG_PRI;
      mode_nxt = SCFR_RST_DEV_CFG[1:0];
      dev_rsvd_nxt = SCFR_RST_DEV_CFG[7:2];
      usr_nxt = SCFR_RST_USR_CFG;
      addr_nxt = '0;
      rd_nxt = 8'h00;
      if (rst_cnt_r == 10'(SCFR_SOFT_RST_CYC - 1)) begin
        rst_act_nxt = 1'b0;
        rst_cnt_nxt = '0;
      end else begin
        rst_cnt_nxt = rst_cnt_r + 10'd1;
      end
    end else if (soft_rst_req) begin
      rst_act_nxt = 1'b1;
      rst_cnt_nxt = '0;
      cfg_pri_nxt = SCFR_RST_CFG_PRI | (8'h01 << SCFR_BIT_SOFT_RST);
    end else if (byte_wr || byte_rd) begin
      if (byte_wr) begin
        if (is_addr(acc_addr, SCFR_ADDR_CFG_PRI)) begin
          cfg_pri_nxt = (wr_data & SCFR_WMASK_CFG_PRI) | (8'h01 << SCFR_BIT_SDO_FLAG);
        end
        if (is_addr(acc_addr, SCFR_ADDR_DEV_CFG)) begin
          mode_nxt = wr_data[1:0];
          dev_rsvd_nxt = wr_data[7:2];
        end
        if (is_addr(acc_addr, SCFR_ADDR_USR_CFG)) begin
          usr_nxt = wr_data;
        end
        // Maker code ignores writes
      end
      if (byte_rd) begin
        rd_nxt = 8'h00;
        if (is_addr(acc_addr, SCFR_ADDR_CFG_PRI)) begin
          rd_nxt = cfg_pri_r | (8'h01 << SCFR_BIT_SDO_FLAG);
        end
        if (is_addr(acc_addr, SCFR_ADDR_DEV_CFG)) begin
          rd_nxt = {dev_rsvd_r, mode_r};
        end
        if (is_addr(acc_addr, SCFR_ADDR_MAKER_LO)) begin
          rd_nxt = MAKER_CODE[7:0];
        end
        if (is_addr(acc_addr, SCFR_ADDR_MAKER_HI)) begin
          rd_nxt = MAKER_CODE[15:8];
        end
        if (is_addr(acc_addr, SCFR_ADDR_USR_CFG)) begin
          rd_nxt = usr_r;
        end
      end
      addr_nxt = step_addr;
    end else if (xfer_start) begin
      addr_nxt = xfer_addr;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg_pri_r <= SCFR_RST_CFG_PRI;
      mode_r <= SCFR_RST_DEV_CFG[1:0];
      dev_rsvd_r <= SCFR_RST_DEV_CFG[7:2];
      usr_r <= SCFR_RST_USR_CFG;
      addr_r <= '0;
      rd_r <= 8'h00;
      rst_cnt_r <= '0;
      rst_act_r <= 1'b0;
    end else begin
      cfg_pri_r <= cfg_pri_nxt;
      mode_r <= mode_nxt;
      dev_rsvd_r <= dev_rsvd_nxt;
      usr_r <= usr_nxt;
      addr_r <= addr_nxt;
      rd_r <= rd_nxt;
      rst_cnt_r <= rst_cnt_nxt;
      rst_act_r <= rst_act_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data = rd_r;
  assign cur_addr = addr_r;
  assign chip_rst = rst_act_r;
  assign busy = rst_act_r; // Host must stay quiet meanwhile
  assign power_down = (mode_r == SCFR_MODE_PWRDN);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Soft reset: starts on request, lasts, clears itself, restores values
  a_soft_rst_start: assert property (@(posedge mclk) disable iff (sys_rst)
    !rst_act_r && soft_rst_req |=> chip_rst) else $error("soft reset not started");
  a_soft_rst_len: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(chip_rst) |-> chip_rst [*8]) else $error("soft reset too short");
  a_soft_rst_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(chip_rst) |-> ##[1:40] !chip_rst ##0 !cfg_pri_r[SCFR_BIT_SOFT_RST]) else $error("reset bit stuck");
  a_rst_values: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(chip_rst) |-> cfg_pri_r == SCFR_RST_CFG_PRI && usr_r == 8'h00 && mode_r == 2'b00)
    else $error("bad reset values");
  // Bank held quiet while the soft reset runs; host accesses are lost then
  a_rst_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    chip_rst |=> rd_data == 8'h00 && cur_addr == '0) else $error("bank not held in reset");

  // Read-only flag and maker code survive any write
  a_flag_reads_one: assert property (@(posedge mclk) disable iff (sys_rst)
    !chip_rst && byte_rd && is_addr(acc_addr, SCFR_ADDR_CFG_PRI) |=> rd_data[SCFR_BIT_SDO_FLAG])
    else $error("flag read zero");
  a_flag_kept: assert property (@(posedge mclk) disable iff (sys_rst)
    !chip_rst && !soft_rst_req && byte_wr && is_addr(acc_addr, SCFR_ADDR_CFG_PRI)
    |=> cfg_pri_r[SCFR_BIT_SDO_FLAG] && !cfg_pri_r[SCFR_BIT_SOFT_RST]) else $error("flag or reset bit stored wrong");
  a_maker_read: assert property (@(posedge mclk) disable iff (sys_rst)
    !chip_rst && !soft_rst_req && byte_rd && is_addr(acc_addr, SCFR_ADDR_MAKER_LO) |=> rd_data == MAKER_CODE[7:0])
    else $error("maker code wrong");
  a_maker_read_hi: assert property (@(posedge mclk) disable iff (sys_rst)
    !chip_rst && !soft_rst_req && byte_rd && is_addr(acc_addr, SCFR_ADDR_MAKER_HI) |=> rd_data == MAKER_CODE[15:8])
    else $error("maker code high byte wrong");

  // Address stepping; hold has priority over direction
  a_addr_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    !chip_rst && !soft_rst_req && byte_rd && usr_r[0] |=> cur_addr == $past(acc_addr))
    else $error("hold moved address");
  a_addr_step: assert property (@(posedge mclk) disable iff (sys_rst)
    !chip_rst && !soft_rst_req && byte_rd && !usr_r[0] && cfg_pri_r[SCFR_BIT_ASCEND]
    |=> cur_addr == $past(acc_addr) + AW'(1)) else $error("address not stepped up");
  a_addr_descend: assert property (@(posedge mclk) disable iff (sys_rst)
    !chip_rst && !soft_rst_req && byte_rd && !usr_r[0] && !cfg_pri_r[SCFR_BIT_ASCEND]
    |=> cur_addr == $past(acc_addr) - AW'(1)) else $error("address not stepped down");

  // Mode field: only code 3 powers the device down
  a_power_down: assert property (@(posedge mclk) disable iff (sys_rst)
    !chip_rst && byte_wr && is_addr(acc_addr, SCFR_ADDR_DEV_CFG)
    && wr_data[1:0] == SCFR_MODE_PWRDN |=> power_down) else $error("power down not entered");
  a_power_up: assert property (@(posedge mclk) disable iff (sys_rst)
    !chip_rst && byte_wr && is_addr(acc_addr, SCFR_ADDR_DEV_CFG)
    && wr_data[1:0] != SCFR_MODE_PWRDN |=> !power_down) else $error("power down without code 3");

  c_soft_rst: cover property (@(posedge mclk) disable iff (sys_rst) $fell(chip_rst));
  c_descend: cover property (@(posedge mclk) disable iff (sys_rst) byte_rd && !cfg_pri_r[SCFR_BIT_ASCEND]);
  c_hold: cover property (@(posedge mclk) disable iff (sys_rst) byte_wr && usr_r[0]);
  c_pwrdn: cover property (@(posedge mclk) disable iff (sys_rst) $rose(power_down));
  c_stream: cover property (@(posedge mclk) disable iff (sys_rst) byte_rd && !xfer_start);
endmodule // scfr_regs
`default_nettype wire

// file: tb/scfr_host.sv
// Host model: serial host issuing single-byte register accesses
`timescale 1ns/1ps
`default_nettype none
module scfr_host
  import scfr_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Byte access towards the register bank
  output logic xfer_start,
  output logic [14:0] xfer_addr,
  output logic byte_wr,
  output logic byte_rd,
  output logic [7:0] wr_data
);
  // ----------------------------------------------------------------
  // Bus idle at time zero
  // ----------------------------------------------------------------
  initial begin
    xfer_start = 1'b0;
    xfer_addr = 15'h0000;
    byte_wr = 1'b0;
    byte_rd = 1'b0;
    wr_data = 8'h00;
  end
  // One transfer per call; released only after the taking edge
  // s low continues a streaming transfer at the running address
  task automatic acc(input logic [14:0] a, input logic w, input logic [7:0] d, input logic s);
    logic [7:0] m;
    begin
      // Reserved bits always go out at their reset value of zero
      m = (a == SCFR_ADDR_CFG_PRI) ? 8'hB0 : (a == SCFR_ADDR_DEV_CFG) ? 8'h03 : 8'h01;
      @(posedge mclk);
      xfer_start <= s;
      xfer_addr <= a;
      byte_wr <= w;
      byte_rd <= !w;
      wr_data <= d & m;
      @(posedge mclk);
      xfer_start <= 1'b0;
      byte_wr <= 1'b0;
      byte_rd <= 1'b0;
      // Released data flips so a stale byte cannot look valid
      wr_data <= ~wr_data;
    end
  endtask
endmodule // scfr_host
`default_nettype wire

// file: tb/tb.sv
// Testbench: register bank checks through single-byte accesses
`timescale 1ns/1ps
`default_nettype none
module tb
  import scfr_pkg::*;
;
  // Arbitrary identification value
  localparam logic [15:0] MK = 16'h3C96;
  logic mclk = 1'b0;
  logic sys_rst;
  logic xfer_start;
  logic [14:0] xfer_addr;
  logic byte_wr;
  logic byte_rd;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [14:0] cur_addr;
  logic chip_rst;
  logic busy;
  logic power_down;
  int err_count = 0;
  int check_count = 0;
  int n;
  // 40 MHz clock
  always #12.5 mclk = ~mclk;
  scfr_host u_host (.mclk(mclk), .xfer_start(xfer_start), .xfer_addr(xfer_addr), .byte_wr(byte_wr),
    .byte_rd(byte_rd), .wr_data(wr_data));
  scfr_regs #(.AW(15), .MAKER_CODE(MK)) u_dut (.mclk(mclk), .sys_rst(sys_rst), .xfer_start(xfer_start),
    .xfer_addr(xfer_addr), .byte_wr(byte_wr), .byte_rd(byte_rd), .wr_data(wr_data), .rd_data(rd_data),
    .cur_addr(cur_addr), .chip_rst(chip_rst), .busy(busy), .power_down(power_down));
  // ----------------------------------------------------------------
  // Compare, access and closing tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    begin
      check_count++;
      if (seen !== exp) begin
        err_count++;
        $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Read data is taken only from the dedicated output
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    begin
      u_host.acc(a, 1'b0, 8'h00, 1'b1);
      #1;
      chk({8'h00, rd_data}, {8'h00, e});
    end
  endtask
  // Streaming read: next byte at the running address
  task automatic rdn(input logic [7:0] e);
    begin
      u_host.acc(15'h0000, 1'b0, 8'h00, 1'b0);
      #1;
      chk({8'h00, rd_data}, {8'h00, e});
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    begin
      u_host.acc(a, 1'b1, d, 1'b1);
      #1;
    end
  endtask
  task automatic results;
    begin
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk({8'h00, rd_data}, 16'h0000);
    chk({1'b0, cur_addr}, 16'h0000);
    chk({14'h0000, chip_rst, power_down}, 16'h0000);
    rd(SCFR_ADDR_CFG_PRI, 8'h30);
    chk({1'b0, cur_addr}, 16'h0001);
    rd(SCFR_ADDR_DEV_CFG, 8'h00);
    rd(SCFR_ADDR_USR_CFG, 8'h00);
    rd(SCFR_ADDR_MAKER_LO, MK[7:0]);
    rd(SCFR_ADDR_MAKER_HI, MK[15:8]);
    // Write attempt on the read-only code must leave it intact
    wr(SCFR_ADDR_MAKER_LO, 8'h5A);
    rd(SCFR_ADDR_MAKER_LO, MK[7:0]);
    wr(SCFR_ADDR_CFG_PRI, 8'h00);
    rd(SCFR_ADDR_CFG_PRI, 8'h10);
    rd(SCFR_ADDR_DEV_CFG, 8'h00);
    chk({1'b0, cur_addr}, 16'h0001);
    wr(SCFR_ADDR_USR_CFG, 8'h01);
    rd(SCFR_ADDR_DEV_CFG, 8'h00);
    chk({1'b0, cur_addr}, 16'h0002);
    // Every mode code, ending in power down
    for (int m = 0; m < 4; m++) begin
      wr(SCFR_ADDR_DEV_CFG, 8'(m));
      chk({15'h0000, power_down}, {15'h0000, m == 3});
      rd(SCFR_ADDR_DEV_CFG, 8'(m));
    end
    wr(SCFR_ADDR_CFG_PRI, 8'h80);
    chk({15'h0000, chip_rst}, 16'h0001);
    // Stay off the bus while the soft reset runs
    n = 0;
    while (busy === 1'b1 && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(16'(n), 16'(SCFR_SOFT_RST_CYC));
    if (n == 40) results();
    rd(SCFR_ADDR_CFG_PRI, 8'h30);
    rd(SCFR_ADDR_USR_CFG, 8'h00);
    rd(SCFR_ADDR_DEV_CFG, 8'h00);
    chk({1'b0, cur_addr}, 16'h0003);
    chk({15'h0000, power_down}, 16'h0000);
    // Streaming reads both ways across the two maker code bytes
    rd(SCFR_ADDR_MAKER_LO, MK[7:0]);
    rdn(MK[15:8]);
    chk({1'b0, cur_addr}, 16'h000E);
    wr(SCFR_ADDR_CFG_PRI, 8'h00);
    rd(SCFR_ADDR_MAKER_HI, MK[15:8]);
    rdn(MK[7:0]);
    chk({1'b0, cur_addr}, 16'h000B);
    results();
  end
endmodule // tb
`default_nettype wire
